// ===== cpm_pkg.sv
`default_nettype none
package cpm_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_BASIC_CTRL = 8'h00;
	localparam logic [7:0] OFS_BASIC_STAT = 8'h04;
	localparam logic [7:0] OFS_EXT_CTRL3 = 8'h08;
	localparam logic [7:0] OFS_EEE_CTRL = 8'h0c;
	localparam logic [7:0] OFS_INT_MASK = 8'h10;
	localparam logic [7:0] OFS_INT_STAT = 8'h14;
	localparam logic [7:0] OFS_WAKE_CFG = 8'h18;
	localparam logic [7:0] OFS_WAKE_ADDR0 = 8'h1c;
	localparam logic [7:0] OFS_WAKE_PWD0 = 8'h28;
	localparam logic [7:0] OFS_EXT_CTRL4 = 8'h34;
	localparam logic [7:0] OFS_AUX_CTRL = 8'h38;
	localparam int ADDR_WORDS = 6;
	// field positions
	localparam int POS_AN_EN = 12;
	localparam int POS_PDOWN = 11;
	localparam int POS_LINK = 2;
	localparam int POS_DS_STAT = 1;
	localparam int POS_DS_CNT = 2;
	localparam int POS_DS_EN = 4;
	localparam int POS_SLEEP = 13;
	localparam int POS_FE_LPI_DIS = 0;
	localparam int POS_WAKE_IRQ = 0;
	localparam int POS_PWD_EN = 0;
	localparam int POS_LED_SEL = 1;
	localparam int POS_PD_STAT = 0;
	localparam int POS_PD_EN = 2;
	localparam int POS_APS_EN = 0;
	localparam int POS_WAKE_TMR = 1;
	localparam int POS_LT_UPPER = 3;
	localparam int POS_LT_LOWER = 5;
	// reset values
	localparam logic AN_EN_RST = 1'b1;
	localparam logic [1:0] SLEEP_RST = 2'h1;
	localparam logic [1:0] DS_CNT_RST = 2'h0;
	localparam logic [1:0] WAKE_TMR_RST = 2'h2;
	localparam logic [1:0] LT_UPPER_RST = 2'h0;
	localparam logic [1:0] LT_LOWER_RST = 2'h1;
	localparam logic [3:0] LFSR_SEED = 4'h9;
	// detection status codes
	localparam logic [1:0] PD_SEARCH = 2'h0;
	localparam logic [1:0] PD_NEEDS_POWER = 2'h1;
	localparam logic [1:0] PD_NONE = 2'h2;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_IN_NS = 1000000;
	localparam int MS_CYC_DEF = MS_IN_NS / CLK_PERIOD_NS;
	localparam int SLEEP_STEP_MS = 1000;
	localparam int RAND_NEG_MS = 80;
	localparam int RAND_STEP_MS = 10;
	localparam int WAKE_STEP_MS = 16;
	localparam int BURST_GAP_MS = 16;
	localparam int BURSTS_MAX = 3;
	localparam int LINK_STEP_MS = 250;
	localparam int PD_TIME_MS = 500;
	localparam int DS_MIN_ATTEMPTS = 2;
	typedef enum logic [1:0] {PM_LOW, PM_WAKE, PM_NORMAL} cpm_pm_state_t;
endpackage : cpm_pkg
`default_nettype wire

// ===== cpm_link_power_manager.sv
// Function
// [R1] fallback advertisement after configured failed gigabit attempts
// [R2] gigabit partner clears fallback without reset
// [R3] fallback enable, attempt count, status bit
// [R4] lpi rx disable selects reduced-amplitude 10M
// [R5] wake detect all speeds, mask enables, pending
// [R6] magic packet raises interrupt or LED
// [R7] per-port wake config and station address
// [R8] host sets detect enable with autoneg on
// [R9] searching sends special pulses, status 00
// [R10] looped pulses give status 01
// [R11] timeout gives 10, detect off, autoneg
// [R12] switch enables power externally on 01
// [R13] link failure returns to detection mode
// [R14] power-save enable bit, writable any time
// [R15] low/wake alternate at programmable rate
// [R16] signal energy enters normal state
// [R17] autoneg link loss: low after timeout
// [R18] reset enters low-power state
// [R19] forced 10/100 stays normal on drop
// [R20] autoneg disabled in normal: stay
// [R21] sleep randomised -80 ms to +60 ms
// [R22] up to three bursts, alternating pairs A/B
// [R23] link timer starts on loss, cancels on restore
`timescale 1ns/100ps
`default_nettype none
module cpm_link_power_manager
	import cpm_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic energy_detect_pin,
	input wire logic flp_loopback_pin,
	input wire logic link_up,
	input wire logic gig_attempt_fail,
	input wire logic partner_gig_seen,
	input wire logic wake_pkt_valid,
	input wire logic [47:0] wake_pkt_addr,
	input wire logic [47:0] wake_pkt_pwd,
	output logic adv_1000,
	output logic reduced_amp_10m,
	output logic autoneg_run,
	output logic pd_flp_tx,
	output logic wake_irq,
	output logic wake_led,
	output logic low_power,
	output logic wake_state,
	output logic flp_burst_tx,
	output logic burst_pair_b
);

	function automatic logic [3:0] reg_index(input logic [7:0] a);
		reg_index = a[5:2];
	endfunction : reg_index

	// pin synchronisers
	// line-side pins are async, so nothing but the second flop reads the first
	logic [1:0] sync1_r;
	logic [1:0] sync2_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
		end else begin
			sync1_r <= {flp_loopback_pin, energy_detect_pin};
			sync2_r <= sync1_r;
		end
	end
	wire energy_s = sync2_r[0];
	wire loopback_s = sync2_r[1];

	// register bus decode
	wire setup_ph = psel && !penable;
	wire access_ph = psel && penable;
	wire [3:0] ridx = reg_index(paddr);
	wire aligned = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
	wire hit_ctrl = aligned && (paddr == OFS_BASIC_CTRL);
	wire hit_stat = aligned && (paddr == OFS_BASIC_STAT);
	wire hit_ext3 = aligned && (paddr == OFS_EXT_CTRL3);
	wire hit_eee = aligned && (paddr == OFS_EEE_CTRL);
	wire hit_imask = aligned && (paddr == OFS_INT_MASK);
	wire hit_istat = aligned && (paddr == OFS_INT_STAT);
	wire hit_wcfg = aligned && (paddr == OFS_WAKE_CFG);
	wire hit_ext4 = aligned && (paddr == OFS_EXT_CTRL4);
	wire hit_aux = aligned && (paddr == OFS_AUX_CTRL);
	wire [3:0] addr_base = reg_index(OFS_WAKE_ADDR0);
	wire hit_mem = aligned && (ridx >= addr_base) && (ridx < addr_base + 4'(ADDR_WORDS));
	wire [2:0] mem_idx = 3'(ridx - addr_base);
	wire mapped = hit_ctrl || hit_stat || hit_ext3 || hit_eee || hit_imask || hit_istat
		|| hit_wcfg || hit_ext4 || hit_aux || hit_mem;
	wire wr_en = access_ph && pwrite && mapped;
	wire rd_done = access_ph && !pwrite;

	// no wait states: every access ends in its first access cycle
	assign pready = 1'b1;
	// unmapped or misaligned accesses finish with an error and change nothing
	assign pslverr = access_ph && !mapped;

	// software registers
	logic an_en_r, pdown_r;
	logic ds_en_r;
	logic [1:0] ds_cnt_r, sleep_sel_r;
	logic fe_lpi_dis_r;
	logic wake_mask_r, wake_pend_r;
	logic pwd_en_r, led_sel_r;
	logic [15:0] mem_r [ADDR_WORDS];
	logic aps_en_r;
	logic [1:0] wake_tmr_r, lt_upper_r, lt_lower_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			an_en_r <= AN_EN_RST;
			pdown_r <= 1'b0;
			ds_en_r <= 1'b0;
			ds_cnt_r <= DS_CNT_RST;
			sleep_sel_r <= SLEEP_RST;
			fe_lpi_dis_r <= 1'b0;
			wake_mask_r <= 1'b0;
			pwd_en_r <= 1'b0;
			led_sel_r <= 1'b0;
			aps_en_r <= 1'b0;
			wake_tmr_r <= WAKE_TMR_RST;
			lt_upper_r <= LT_UPPER_RST;
			lt_lower_r <= LT_LOWER_RST;
		end else if (wr_en) begin
			if (hit_ctrl) begin
				an_en_r <= pwdata[POS_AN_EN];
				pdown_r <= pwdata[POS_PDOWN];
			end
			if (hit_ext3) begin
				ds_en_r <= pwdata[POS_DS_EN]; // [R3]
				ds_cnt_r <= pwdata[POS_DS_CNT +: 2]; // [R3]
				sleep_sel_r <= pwdata[POS_SLEEP +: 2];
			end
			if (hit_eee)
				fe_lpi_dis_r <= pwdata[POS_FE_LPI_DIS]; // [R4]
			if (hit_imask)
				wake_mask_r <= pwdata[POS_WAKE_IRQ]; // [R5]
			if (hit_wcfg) begin
				pwd_en_r <= pwdata[POS_PWD_EN]; // [R7]
				led_sel_r <= pwdata[POS_LED_SEL];
			end
			if (hit_aux) begin
				aps_en_r <= pwdata[POS_APS_EN]; // [R14]
				wake_tmr_r <= pwdata[POS_WAKE_TMR +: 2];
				lt_upper_r <= pwdata[POS_LT_UPPER +: 2];
				lt_lower_r <= pwdata[POS_LT_LOWER +: 2];
			end
		end
	end

	// station address words 0..2, password words 3..5
	genvar gi;
	generate
		for (gi = 0; gi < ADDR_WORDS; gi++) begin : g_mem
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					mem_r[gi] <= 16'h0;
				else if (wr_en && hit_mem && (mem_idx == 3'(gi)))
					mem_r[gi] <= pwdata[15:0]; // [R7]
			end
		end
	endgenerate

	// wake packet
	wire [47:0] station = {mem_r[2], mem_r[1], mem_r[0]};
	wire [47:0] password = {mem_r[5], mem_r[4], mem_r[3]};
	// no speed gating: the decoder feeds this at every link speed
	wire wake_hit = wake_pkt_valid && wake_mask_r && (wake_pkt_addr == station)
		&& (!pwd_en_r || (wake_pkt_pwd == password)); // [R5] [R7]
	// clear only a pending bit that the read returned: a hit landing at
	// the setup edge stays pending for the next read instead of being lost
	wire wake_clr = rd_done && hit_istat
		&& prdata[POS_WAKE_IRQ]; // [R5]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wake_pend_r <= 1'b0;
		else if (wake_hit)
			wake_pend_r <= 1'b1; // [R5]
		else if (wake_clr)
			wake_pend_r <= 1'b0;
	end

	assign wake_irq = wake_pend_r && wake_mask_r && !led_sel_r; // [R6]
	assign wake_led = wake_pend_r && wake_mask_r && led_sel_r; // [R6]

	// speed fallback
	// a gigabit partner or a disable clears it; a good link restarts the count
	logic [2:0] fail_cnt_r;
	logic ds_act_r;
	wire [2:0] ds_limit = 3'(ds_cnt_r) + 3'(DS_MIN_ATTEMPTS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fail_cnt_r <= 3'h0;
			ds_act_r <= 1'b0;
		end else if (partner_gig_seen || !ds_en_r) begin
			fail_cnt_r <= 3'h0;
			ds_act_r <= 1'b0; // [R2]
		end else if (gig_attempt_fail && !ds_act_r) begin
			if (fail_cnt_r + 3'h1 >= ds_limit)
				ds_act_r <= 1'b1; // [R1]
			fail_cnt_r <= fail_cnt_r + 3'h1;
		end else if (link_up) begin
			fail_cnt_r <= 3'h0;
		end
	end

	assign adv_1000 = !ds_act_r; // [R1]
	assign reduced_amp_10m = fe_lpi_dis_r; // [R4]

	// millisecond tick
	// free-running, so a ms timer may end up to one tick early
	logic [31:0] pres_r;
	wire tick = (pres_r == 32'(MS_CYCLES - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pres_r <= 32'h0;
		else
			pres_r <= tick ? 32'h0 : pres_r + 32'h1;
	end

	// inline power detection
	// a link drop after a finished detection starts a new search
	logic pd_en_r, pd_used_r;
	logic [1:0] pd_stat_r;
	logic [9:0] pd_ms_r;
	wire pd_search = pd_en_r && an_en_r && (pd_stat_r == PD_SEARCH);
	wire pd_sw_wr = wr_en && hit_ext4;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_en_r <= 1'b0;
			pd_stat_r <= PD_SEARCH;
			pd_used_r <= 1'b0;
			pd_ms_r <= 10'h0;
		end else begin
			pd_ms_r <= !pd_search ? 10'h0 : pd_ms_r + 10'(tick);
			if (pd_used_r && !link_up) begin
				pd_en_r <= 1'b1; // [R13]
				pd_stat_r <= PD_SEARCH;
				pd_used_r <= 1'b0;
			end else if (pd_search && loopback_s) begin
				pd_stat_r <= PD_NEEDS_POWER; // [R10]
			end else if (pd_search && pd_ms_r >= 10'(PD_TIME_MS)) begin
				pd_stat_r <= PD_NONE; // [R11]
				pd_en_r <= 1'b0; // [R11]
			end else if (pd_sw_wr) begin
				pd_en_r <= pwdata[POS_PD_EN];
				pd_stat_r <= PD_SEARCH; // [R9]
			end else if (link_up && pd_stat_r != PD_SEARCH) begin
				pd_used_r <= 1'b1;
			end
		end
	end

	assign pd_flp_tx = pd_search; // [R9]
	// needs-power keeps detect enabled, so autoneg stays parked until software clears the enable
	assign autoneg_run = an_en_r && !pd_en_r; // [R11]

	// power-save state machine
	// lfsr steps once per sleep so two sleeping ports drift apart
	cpm_pm_state_t st_r, st_nxt;
	logic [12:0] tmr_r;
	logic [3:0] lfsr_r;
	logic [1:0] burst_cnt_r;
	logic pair_b_r;

	wire [12:0] sleep_ms = 13'(SLEEP_STEP_MS * (int'(sleep_sel_r) + 1) - RAND_NEG_MS
		+ RAND_STEP_MS * (int'(lfsr_r) - 1)); // [R15] [R21]
	wire [12:0] wake_ms = 13'(WAKE_STEP_MS * (int'(wake_tmr_r) + 1));
	wire [12:0] link_ms = 13'(LINK_STEP_MS * (int'({lt_upper_r, lt_lower_r}) + 1));
	// autoneg off (forced speed) never leaves normal on a drop
	wire link_lost = an_en_r && !link_up; // [R17] [R19] [R20]
	wire burst_fire = (st_r == PM_WAKE) && (burst_cnt_r < 2'(BURSTS_MAX))
		&& (tmr_r >= 13'(BURST_GAP_MS * int'(burst_cnt_r))) && (tmr_r < wake_ms);

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			PM_LOW: begin
				if (!aps_en_r || energy_s)
					st_nxt = PM_NORMAL; // [R16]
				else if (tmr_r >= sleep_ms)
					st_nxt = PM_WAKE; // [R15]
			end
			PM_WAKE: begin
				if (!aps_en_r || energy_s)
					st_nxt = PM_NORMAL; // [R16]
				else if (tmr_r >= wake_ms)
					st_nxt = PM_LOW; // [R22]
			end
			PM_NORMAL: begin
				if (aps_en_r && link_lost && tmr_r >= link_ms)
					st_nxt = PM_LOW; // [R17]
			end
		endcase
	end

	wire st_chg = (st_nxt != st_r);
	// timer runs only while waiting; a restored link cancels it
	wire tmr_hold = (st_r == PM_NORMAL) && !link_lost; // [R23]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= PM_LOW; // [R18]
			tmr_r <= 13'h0;
			lfsr_r <= LFSR_SEED;
			burst_cnt_r <= 2'h0;
			pair_b_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			if (st_chg || tmr_hold)
				tmr_r <= 13'h0; // [R23]
			else
				tmr_r <= tmr_r + 13'(tick);
			if (st_chg && st_nxt == PM_LOW)
				lfsr_r <= {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]}; // [R21]
			if (st_r != PM_WAKE)
				burst_cnt_r <= 2'h0;
			else if (burst_fire)
				burst_cnt_r <= burst_cnt_r + 2'h1; // [R22]
			if (burst_fire)
				pair_b_r <= !pair_b_r; // [R22]
		end
	end

	assign flp_burst_tx = burst_fire; // [R22]
	assign burst_pair_b = pair_b_r;
	assign low_power = pdown_r || (st_r == PM_LOW);
	assign wake_state = (st_r == PM_WAKE);

	// read data
	// 16-bit fields read back zero-extended
	wire [31:0] rd_ctrl = 32'({an_en_r, pdown_r}) << POS_PDOWN;
	wire [31:0] rd_stat = 32'(link_up) << POS_LINK;
	wire [31:0] rd_ext3 = (32'(sleep_sel_r) << POS_SLEEP) | (32'(ds_en_r) << POS_DS_EN)
		| (32'(ds_cnt_r) << POS_DS_CNT) | (32'(ds_act_r) << POS_DS_STAT); // [R3]
	wire [31:0] rd_ext4 = (32'(pd_en_r) << POS_PD_EN) | (32'(pd_stat_r) << POS_PD_STAT);
	wire [31:0] rd_aux = (32'(lt_lower_r) << POS_LT_LOWER) | (32'(lt_upper_r) << POS_LT_UPPER)
		| (32'(wake_tmr_r) << POS_WAKE_TMR) | (32'(aps_en_r) << POS_APS_EN);
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_stat ? rd_stat :
		hit_ext3 ? rd_ext3 :
		hit_eee ? 32'(fe_lpi_dis_r) :
		hit_imask ? 32'(wake_mask_r) :
		hit_istat ? 32'(wake_pend_r) :
		hit_wcfg ? 32'({led_sel_r, pwd_en_r}) :
		hit_ext4 ? rd_ext4 :
		hit_aux ? rd_aux :
		hit_mem ? 32'(mem_r[mem_idx]) : 32'h0;

	// captured in setup so prdata is stable through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0;
		else if (setup_ph)
			prdata <= rd_mux;
	end

endmodule : cpm_link_power_manager
`default_nettype wire

// ===== cpm_chk.sv
`timescale 1ns/100ps
`default_nettype none
module cpm_chk #(
	parameter int MS_CYCLES = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic gig_attempt_fail,
	input wire logic partner_gig_seen,
	input wire logic energy_detect_pin,
	input wire logic adv_1000,
	input wire logic autoneg_run,
	input wire logic pd_flp_tx,
	input wire logic wake_irq,
	input wire logic wake_led,
	input wire logic low_power,
	input wire logic wake_state,
	input wire logic flp_burst_tx,
	input wire logic burst_pair_b
);
	// longest wake window (64 ms) plus six ms of margin
	localparam int WAKE_MAX = 70 * MS_CYCLES;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_energy_held;
		energy_detect_pin [*4];
	endsequence
	// window too long for a delay range, so count it in a helper
	logic [31:0] wake_cyc_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wake_cyc_r <= 32'h0;
		else
			wake_cyc_r <= wake_state ? wake_cyc_r + 32'h1 : 32'h0;
	end
	a_reset_low: assert property ($rose(presetn) |-> low_power)
		else $error("not low after reset");
	a_detect_excl: assert property (pd_flp_tx |-> !autoneg_run)
		else $error("search while autoneg runs");
	a_irq_or_led: assert property (!(wake_irq && wake_led))
		else $error("irq and led together");
	a_burst_in_wake: assert property (flp_burst_tx |-> wake_state)
		else $error("burst outside wake");
	a_pair_alt: assert property (flp_burst_tx |=> burst_pair_b != $past(burst_pair_b))
		else $error("pair did not alternate");
	a_energy_wins: assert property (s_energy_held |-> !wake_state)
		else $error("energy left in wake");
	a_wake_ends: assert property (wake_cyc_r < 32'(WAKE_MAX))
		else $error("wake state too long");
	a_fb_cause: assert property ($fell(adv_1000) |->
		$past(gig_attempt_fail) || $past(gig_attempt_fail, 2)) else $error("fallback uncaused");
	a_fb_clear: assert property (partner_gig_seen && !gig_attempt_fail |-> ##[1:2] adv_1000)
		else $error("fallback not cleared");
endmodule : cpm_chk
bind cpm_link_power_manager cpm_chk #(.MS_CYCLES(MS_CYCLES)) chk_u (.pclk, .presetn,
	.gig_attempt_fail, .partner_gig_seen, .energy_detect_pin, .adv_1000, .autoneg_run,
	.pd_flp_tx, .wake_irq, .wake_led, .low_power, .wake_state, .flp_burst_tx, .burst_pair_b);
`default_nettype wire

// ===== cpm_partner.sv
`timescale 1ns/100ps
`default_nettype none
module cpm_partner #(
	parameter int DELAY = 4
) (
	input wire logic pclk,
	input wire logic plugged,
	input wire logic powered,
	input wire logic link_ok,
	input wire logic pd_flp_tx,
	output logic energy_detect_pin,
	output logic flp_loopback_pin,
	output logic link_up
);
	int cnt_r;
	// energy only once the powered partner has started up
	always_ff @(posedge pclk) begin
		if (plugged && powered)
			cnt_r <= cnt_r + int'(cnt_r < DELAY);
		else
			cnt_r <= 0;
	end
	assign energy_detect_pin = (cnt_r == DELAY);
	// an unpowered inline device shorts the pulses back
	assign flp_loopback_pin = plugged && !powered && pd_flp_tx;
	assign link_up = energy_detect_pin && link_ok;
endmodule : cpm_partner
`default_nettype wire

// ===== cpm_link_power_manager_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cpm_link_power_manager_tb;
	import cpm_pkg::*;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} cpm_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, plugged, powered, link_ok;
	logic gig_attempt_fail, partner_gig_seen, wake_pkt_valid, energy_detect_pin, flp_loopback_pin;
	logic link_up, adv_1000, reduced_amp_10m, autoneg_run, pd_flp_tx, wake_irq, wake_led;
	logic low_power, wake_state, flp_burst_tx, burst_pair_b, in_win;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [47:0] wake_pkt_addr, wake_pkt_pwd;
	int miscompares, samples_checked, n, bursts;
	cpm_row_t rows[8] = '{
		'{1'h0, OFS_BASIC_CTRL, 32'h0, 32'h1000, 1'h0},
		'{1'h1, OFS_EEE_CTRL, 32'h1, 32'h1, 1'h0},
		'{1'h1, OFS_WAKE_ADDR0, 32'h1234, 32'h1234, 1'h0},
		'{1'h1, OFS_WAKE_ADDR0 + 8'h4, 32'h5678, 32'h5678, 1'h0},
		'{1'h1, OFS_WAKE_ADDR0 + 8'h8, 32'h9abc, 32'h9abc, 1'h0},
		'{1'h1, OFS_INT_MASK, 32'h1, 32'h1, 1'h0},
		'{1'h1, OFS_EXT_CTRL3, 32'h10, 32'h10, 1'h0},
		'{1'h1, 8'h3c, 32'h5a5a, 32'h0, 1'h1}
	};
	cpm_link_power_manager #(.MS_CYCLES(10)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .energy_detect_pin, .flp_loopback_pin,
		.link_up, .gig_attempt_fail, .partner_gig_seen, .wake_pkt_valid, .wake_pkt_addr,
		.wake_pkt_pwd, .adv_1000, .reduced_amp_10m, .autoneg_run, .pd_flp_tx, .wake_irq,
		.wake_led, .low_power, .wake_state, .flp_burst_tx, .burst_pair_b);
	cpm_partner #(.DELAY(4)) far_u (.pclk, .plugged, .powered, .link_ok, .pd_flp_tx,
		.energy_detect_pin, .flp_loopback_pin, .link_up);
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	task automatic complete_run();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
		@(posedge pclk);
	endtask : apb
	// w: 0 wake packet, 1 failed gigabit try, 2 gigabit partner
	task automatic pulse(input int w);
		{partner_gig_seen, gig_attempt_fail, wake_pkt_valid} <= 3'h1 << w;
		@(posedge pclk);
		{partner_gig_seen, gig_attempt_fail, wake_pkt_valid} <= 3'h0;
		repeat (2) @(posedge pclk);
	endtask : pulse
	initial begin
		{psel, penable, pwrite, paddr, pwdata, plugged, powered, link_ok, presetn} = '0;
		{partner_gig_seen, gig_attempt_fail, wake_pkt_valid, wake_pkt_pwd} = '0;
		wake_pkt_addr = 48'h9abc_5678_1234;
		repeat (10) @(posedge pclk);
		chk("low_power", 1'h1, low_power);
		presetn <= 1'h1;
		foreach (rows[i]) begin
			if (rows[i].wr) apb(1'h1, rows[i].a, rows[i].d);
			apb(1'h0, rows[i].a, 32'h0);
			chk("read", rows[i].q, q);
			chk("slverr", rows[i].e, e);
		end
		chk("reduced_amp_10m", 1'h1, reduced_amp_10m);
		for (int i = 0; i < 2; i++) begin
			pulse(0);
			chk("wake_irq", !i[0], wake_irq);
			chk("wake_led", i[0], wake_led);
			apb(1'h0, OFS_INT_STAT, 32'h0);
			chk("pending", 32'h1, q);
			apb(1'h1, OFS_WAKE_CFG, 32'h2);
		end
		chk("wake_led", 1'h0, wake_led);
		apb(1'h1, OFS_WAKE_PWD0, 32'hc3);
		apb(1'h1, OFS_WAKE_CFG, 32'h3);
		pulse(0);
		chk("wake_led", 1'h0, wake_led);
		wake_pkt_pwd <= 48'hc3;
		pulse(0);
		chk("wake_led", 1'h1, wake_led);
		apb(1'h0, OFS_INT_STAT, 32'h0);
		chk("pending", 32'h1, q);
		pulse(1);
		chk("adv_1000", 1'h1, adv_1000);
		pulse(1);
		chk("adv_1000", 1'h0, adv_1000);
		apb(1'h0, OFS_EXT_CTRL3, 32'h0);
		chk("fallback", 32'h12, q);
		pulse(2);
		chk("adv_1000", 1'h1, adv_1000);
		apb(1'h1, OFS_EXT_CTRL4, 32'h4);
		chk("pd_flp_tx", 1'h1, pd_flp_tx);
		apb(1'h0, OFS_EXT_CTRL4, 32'h0);
		chk("detect", PD_SEARCH, q[1:0]);
		plugged <= 1'h1;
		repeat (6) @(posedge pclk);
		apb(1'h0, OFS_EXT_CTRL4, 32'h0);
		chk("detect", PD_NEEDS_POWER, q[1:0]);
		{powered, link_ok} <= 2'h3;
		repeat (8) @(posedge pclk);
		{plugged, powered} <= 2'h0;
		for (n = 0; n < 10 && pd_flp_tx !== 1'h1; n++) @(posedge pclk);
		chk("pd_flp_tx", 1'h1, pd_flp_tx);
		for (n = 0; n < 6000 && pd_flp_tx !== 1'h0; n++) @(posedge pclk);
		in_win = n > (PD_TIME_MS - 2) * 10 && n < (PD_TIME_MS + 2) * 10;
		chk("detect time", 1'h1, in_win);
		apb(1'h0, OFS_EXT_CTRL4, 32'h0);
		chk("detect", {PD_NONE}, q);
		chk("autoneg_run", 1'h1, autoneg_run);
		{plugged, powered} <= 2'h3;
		apb(1'h1, OFS_AUX_CTRL, 32'h5);
		apb(1'h0, OFS_AUX_CTRL, 32'h0);
		chk("aux", 32'h5, q);
		// a timer left running would expire early in the second drop
		plugged <= 1'h0;
		repeat (2000) @(posedge pclk);
		plugged <= 1'h1;
		repeat (20) @(posedge pclk);
		plugged <= 1'h0;
		for (n = 0; n < 3000 && low_power !== 1'h1; n++) @(posedge pclk);
		in_win = n > (LINK_STEP_MS - 2) * 10 && n < (LINK_STEP_MS + 2) * 10;
		chk("link time", 1'h1, in_win);
		for (n = 0; n < 11000 && wake_state !== 1'h1; n++) @(posedge pclk);
		chk("sleep", 1'h1, n > (SLEEP_STEP_MS - RAND_NEG_MS - 2) * 10 && n < 10620);
		bursts = 0;
		for (n = 0; n < 800 && wake_state === 1'h1; n++) begin
			bursts += int'(flp_burst_tx);
			@(posedge pclk);
		end
		chk("bursts", BURSTS_MAX, bursts);
		chk("burst_pair_b", 1'h1, burst_pair_b);
		chk("low_power", 1'h1, low_power);
		plugged <= 1'h1;
		for (n = 0; n < 20 && low_power !== 1'h0; n++) @(posedge pclk);
		chk("energy wake", 1'h1, n < 12);
		apb(1'h1, OFS_BASIC_CTRL, 32'h0);
		plugged <= 1'h0;
		repeat (3000) @(posedge pclk);
		chk("low_power", 1'h0, low_power);
		complete_run();
	end
	initial begin
		repeat (40000) @(posedge pclk);
		miscompares++;
		complete_run();
	end
endmodule : cpm_link_power_manager_tb
`default_nettype wire
